// File: design/csfl_flags.sv
// condition flag generation and main/alternate flag registers
//
// Contract
// RULE_01: flag byte S7 Z6 H4 PV2 N1 C0, both copies
// RULE_02: bits three and five carry no status
// RULE_03: branch tests use only C, PV, Z, S
// RULE_04: carry equals add carry or subtract borrow
// RULE_05: decimal adjust sets carry when correcting
// RULE_06: left rotates/shift load carry from bit 7
// RULE_07: right rotates/shifts load carry from bit 0
// RULE_08: and, or, xor clear carry
// RULE_09: set-carry and complement-carry operations exist
// RULE_10: add clears N, subtract sets N
// RULE_11: add overflow on like signs, changed sign
// RULE_12: subtract overflow only on unlike signs
// RULE_13: logic and rotate give even parity flag
// RULE_14: block ops: PV clear when counter zero
// RULE_15: load from vector/refresh copies interrupt enable
// RULE_16: port input sets parity, zero, sign
// RULE_17: half carry from bit 3 or borrow bit 4
// RULE_18: zero set when result byte is zero
// RULE_19: compare sets zero when operands equal
// RULE_20: bit test loads zero with inverted bit
// RULE_21: block io zero when decremented b zero
// RULE_22: sign copies result bit 7
// RULE_23: unaffected flags and unused bits keep value
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
module csfl_flags #(
  parameter int unsigned DATA_W = 8  // datapath width, only 8 is served
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // flag update request
  input  wire logic              req_valid,
  input  wire csfl_pkg::csfl_req_t req,
  output csfl_pkg::csfl_rsp_t    rsp,
  // condition test
  input  wire csfl_pkg::csfl_cc_t cc_sel,
  output logic                   cc_true,
  // register port
  input  wire logic [1:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata
);
  // elaboration check: the flag logic is written for byte operands only
  if (DATA_W != 8) begin : g_width_check
    $error("csfl_flags serves only an 8-bit datapath");
  end

  // all checks sample on the core clock and pause while reset is low
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  logic [7:0] flags;      // main flag byte
  logic [7:0] flags_alt;  // alternate flag byte
  logic [7:0] next_flags; // updated main flag byte
  logic [7:0] next_res;   // computed result byte

  // operand decode
  wire csfl_pkg::csfl_op_t op = req.op;
  wire [7:0] a = req.opa;
  wire [7:0] b = req.opb;
  wire c_in = flags[csfl_pkg::FLAG_CARRY];
  wire use_c = (op == csfl_pkg::CSFL_OP_ADC) || (op == csfl_pkg::CSFL_OP_SBC);
  wire cin = use_c & c_in;
  wire is_sub = (op == csfl_pkg::CSFL_OP_SUB) || (op == csfl_pkg::CSFL_OP_SBC) ||
                (op == csfl_pkg::CSFL_OP_CMP);
  wire is_add = (op == csfl_pkg::CSFL_OP_ADD) || (op == csfl_pkg::CSFL_OP_ADC);

  // adder: 9-bit sums, half sums give bit-3 carry / bit-4 borrow
  wire [8:0] sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire [8:0] dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  wire [4:0] hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  wire [4:0] hdif = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
  // like signs with changed sign overflows an add
  wire ov_add = (a[7] == b[7]) && (sum9[7] != a[7]);
  // only unlike signs can overflow a subtract
  wire ov_sub = (a[7] != b[7]) && (dif9[7] != a[7]);

  // decimal adjust correction; the subtract flag picks the direction
  wire adj_lo = flags[csfl_pkg::FLAG_HALF] || (a[3:0] > 4'h9);
  wire adj_hi = c_in || (a > 8'h99);
  wire [7:0] adj_cor = {adj_hi ? 4'h6 : 4'h0, adj_lo ? 4'h6 : 4'h0};
  wire adj_subm = flags[csfl_pkg::FLAG_SUB];
  wire [7:0] adj_res = adj_subm ? (a - adj_cor) : (a + adj_cor);
  wire adj_h = adj_subm ? (adj_lo && (a[3:0] < 4'h6)) : (adj_lo && (a[3:0] > 4'h9));

  // parity helper: even count of ones gives 1
  function automatic logic even_par(input logic [7:0] v);
    even_par = ~^v;
  endfunction

  // result and flag selection
  always_comb begin
    next_res   = a;
    next_flags = flags;  // RULE_23
    case (op)
      csfl_pkg::CSFL_OP_ADD, csfl_pkg::CSFL_OP_ADC: begin
        next_res = sum9[7:0];
        next_flags[csfl_pkg::FLAG_CARRY] = sum9[8];  // RULE_04
        next_flags[csfl_pkg::FLAG_HALF]  = hsum[4];  // RULE_17
        next_flags[csfl_pkg::FLAG_PV]    = ov_add;   // RULE_11
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;     // RULE_10
      end
      csfl_pkg::CSFL_OP_SUB, csfl_pkg::CSFL_OP_SBC, csfl_pkg::CSFL_OP_CMP: begin
        next_res = (op == csfl_pkg::CSFL_OP_CMP) ? a : dif9[7:0];
        next_flags[csfl_pkg::FLAG_CARRY] = dif9[8];  // RULE_04
        next_flags[csfl_pkg::FLAG_HALF]  = hdif[4];  // RULE_17
        next_flags[csfl_pkg::FLAG_PV]    = ov_sub;   // RULE_12
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b1;     // RULE_10
      end
      csfl_pkg::CSFL_OP_AND, csfl_pkg::CSFL_OP_OR, csfl_pkg::CSFL_OP_XOR: begin
        next_res = (op == csfl_pkg::CSFL_OP_AND) ? (a & b) :
                   (op == csfl_pkg::CSFL_OP_OR)  ? (a | b) : (a ^ b);
        next_flags[csfl_pkg::FLAG_CARRY] = 1'b0;     // RULE_08
        next_flags[csfl_pkg::FLAG_HALF]  = (op == csfl_pkg::CSFL_OP_AND);
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_DECIMAL_ADJUST_ACC: begin
        next_res = adj_res;
        next_flags[csfl_pkg::FLAG_CARRY] = adj_hi;   // RULE_05
        next_flags[csfl_pkg::FLAG_HALF]  = adj_h;
      end
      csfl_pkg::CSFL_OP_RLC: begin
        next_res = {a[6:0], a[7]};
        next_flags[csfl_pkg::FLAG_CARRY] = a[csfl_pkg::ACC_MSB];  // RULE_06
      end
      csfl_pkg::CSFL_OP_SLA: begin
        next_res = {a[6:0], 1'b0};
        next_flags[csfl_pkg::FLAG_CARRY] = a[csfl_pkg::ACC_MSB];  // RULE_06
      end
      csfl_pkg::CSFL_OP_RL: begin
        next_res = {a[6:0], c_in};                   // RULE_06
        next_flags[csfl_pkg::FLAG_CARRY] = a[csfl_pkg::ACC_MSB];
      end
      csfl_pkg::CSFL_OP_RRC: begin
        next_res = {a[0], a[7:1]};
        next_flags[csfl_pkg::FLAG_CARRY] = a[0];     // RULE_07
      end
      csfl_pkg::CSFL_OP_RR: begin
        next_res = {c_in, a[7:1]};
        next_flags[csfl_pkg::FLAG_CARRY] = a[0];     // RULE_07
      end
      csfl_pkg::CSFL_OP_SRA: begin
        next_res = {a[7], a[7:1]};
        next_flags[csfl_pkg::FLAG_CARRY] = a[0];     // RULE_07
      end
      csfl_pkg::CSFL_OP_SRL: begin
        next_res = {1'b0, a[7:1]};
        next_flags[csfl_pkg::FLAG_CARRY] = a[0];     // RULE_07
      end
      csfl_pkg::CSFL_OP_SET_CARRY: begin
        next_flags[csfl_pkg::FLAG_CARRY] = 1'b1;     // RULE_09
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
        next_flags[csfl_pkg::FLAG_HALF]  = 1'b0;
      end
      csfl_pkg::CSFL_OP_COMPLEMENT_CARRY: begin
        next_flags[csfl_pkg::FLAG_CARRY] = ~c_in;    // RULE_09
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_BIT: begin
        next_flags[csfl_pkg::FLAG_ZERO]  = ~b[req.bit_sel];  // RULE_20
        next_flags[csfl_pkg::FLAG_HALF]  = 1'b1;
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_BLKCP: begin
        next_flags[csfl_pkg::FLAG_PV]    = (req.counter != 16'h0000);  // RULE_14
        next_flags[csfl_pkg::FLAG_ZERO]  = (a == b);                   // RULE_19
        next_flags[csfl_pkg::FLAG_SIGN]  = dif9[7];
        next_flags[csfl_pkg::FLAG_HALF]  = hdif[4];
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b1;
      end
      csfl_pkg::CSFL_OP_BLKLD: begin
        next_flags[csfl_pkg::FLAG_PV]    = (req.counter != 16'h0000);  // RULE_14
        next_flags[csfl_pkg::FLAG_HALF]  = 1'b0;
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_LDAIR: begin
        next_res = b;
        next_flags[csfl_pkg::FLAG_PV]    = req.ie_copy;  // RULE_15
        next_flags[csfl_pkg::FLAG_ZERO]  = (b == 8'h00);
        next_flags[csfl_pkg::FLAG_SIGN]  = b[csfl_pkg::ACC_MSB];
        next_flags[csfl_pkg::FLAG_HALF]  = 1'b0;
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_INR: begin
        next_res = b;
        next_flags[csfl_pkg::FLAG_PV]    = even_par(b);            // RULE_16
        next_flags[csfl_pkg::FLAG_ZERO]  = (b == 8'h00);           // RULE_16
        next_flags[csfl_pkg::FLAG_SIGN]  = b[csfl_pkg::ACC_MSB];   // RULE_16
        next_flags[csfl_pkg::FLAG_HALF]  = 1'b0;
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b0;
      end
      csfl_pkg::CSFL_OP_BLKIO: begin
        next_flags[csfl_pkg::FLAG_ZERO]  = (req.b_dec == 8'h00);   // RULE_21
        next_flags[csfl_pkg::FLAG_SUB]   = 1'b1;
      end
      default: begin
        next_res = a;                                // none: nothing changes
      end
    endcase
    // common sign/zero for byte-result ops, parity for all but add/subtract/compare
    if (is_add || is_sub || op == csfl_pkg::CSFL_OP_DECIMAL_ADJUST_ACC ||
        op == csfl_pkg::CSFL_OP_AND || op == csfl_pkg::CSFL_OP_OR ||
        op == csfl_pkg::CSFL_OP_XOR || op == csfl_pkg::CSFL_OP_RLC ||
        op == csfl_pkg::CSFL_OP_RRC || op == csfl_pkg::CSFL_OP_RL ||
        op == csfl_pkg::CSFL_OP_RR  || op == csfl_pkg::CSFL_OP_SLA ||
        op == csfl_pkg::CSFL_OP_SRA || op == csfl_pkg::CSFL_OP_SRL) begin
      // compare keeps a, so its zero means equality
      next_flags[csfl_pkg::FLAG_ZERO] = (op == csfl_pkg::CSFL_OP_CMP) ?
                                        (a == b) : (next_res == 8'h00);  // RULE_18 RULE_19
      next_flags[csfl_pkg::FLAG_SIGN] = (op == csfl_pkg::CSFL_OP_CMP) ?
                                        dif9[7] : next_res[csfl_pkg::ACC_MSB];  // RULE_22
      if (!is_add && !is_sub) begin
        next_flags[csfl_pkg::FLAG_PV] = even_par(next_res);  // RULE_13
      end
      if (op >= csfl_pkg::CSFL_OP_RLC) begin
        next_flags[csfl_pkg::FLAG_HALF] = 1'b0;
        next_flags[csfl_pkg::FLAG_SUB]  = 1'b0;
      end
    end
  end

  // register port decode; bits 3 and 5 simply store what is loaded
  wire wr_flags = reg_wr && (reg_addr == csfl_pkg::ADDR_FLAGS);
  wire wr_alt   = reg_wr && (reg_addr == csfl_pkg::ADDR_FLAGS_ALT);
  wire do_swap  = reg_wr && (reg_addr == csfl_pkg::ADDR_CTRL) &&
                  reg_wdata[csfl_pkg::CTRL_SWAP];
  wire do_upd   = req_valid && (op != csfl_pkg::CSFL_OP_NONE);

  // flag registers; an operation update wins over a software write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags     <= csfl_pkg::FLAGS_RST;
      flags_alt <= csfl_pkg::FLAGS_RST;
    end else if (clk_en) begin
      if (do_upd) begin
        flags <= next_flags;  // RULE_01 RULE_02
      end else if (do_swap) begin
        flags     <= flags_alt;
        flags_alt <= flags;
      end else if (wr_flags) begin
        flags <= reg_wdata;   // RULE_23
      end else if (wr_alt) begin
        flags_alt <= reg_wdata;
      end
    end
  end

  // result register and read data, both flopped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp       <= '0;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (do_upd) begin
        rsp <= '{result: next_res, flags: next_flags};
      end
      reg_rdata <= !reg_rd ? 8'h00 :
                   (reg_addr == csfl_pkg::ADDR_FLAGS)     ? flags :
                   (reg_addr == csfl_pkg::ADDR_FLAGS_ALT) ? flags_alt : 8'h00;
    end
  end

  // branch condition: only four flags are testable
  always_comb begin
    case (cc_sel)
      csfl_pkg::CSFL_CC_NZ: cc_true = ~flags[csfl_pkg::FLAG_ZERO];   // RULE_03
      csfl_pkg::CSFL_CC_Z:  cc_true =  flags[csfl_pkg::FLAG_ZERO];
      csfl_pkg::CSFL_CC_NC: cc_true = ~flags[csfl_pkg::FLAG_CARRY];
      csfl_pkg::CSFL_CC_C:  cc_true =  flags[csfl_pkg::FLAG_CARRY];
      csfl_pkg::CSFL_CC_PO: cc_true = ~flags[csfl_pkg::FLAG_PV];
      csfl_pkg::CSFL_CC_PE: cc_true =  flags[csfl_pkg::FLAG_PV];
      csfl_pkg::CSFL_CC_P:  cc_true = ~flags[csfl_pkg::FLAG_SIGN];
      default:              cc_true =  flags[csfl_pkg::FLAG_SIGN];
    endcase
  end

  // checks; take marks a request seen by an enabled edge
  wire take = clk_en && req_valid;
  a_add_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_04
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_ADD) |=> flags[0] == $past(sum9[8]))
    else $error("add carry wrong");
  a_sub_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_10
    (clk_en && req_valid && is_sub) |=> flags[1])
    else $error("subtract flag not set");
  a_logic_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_08
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_XOR) |=> !flags[0])
    else $error("logic op left carry");
  a_rlc_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_06
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_RLC) |=> flags[0] == $past(a[7]))
    else $error("rotate left carry wrong");
  a_srl_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_07
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_SRL) |=> flags[0] == $past(a[0]))
    else $error("shift right carry wrong");
  a_carry_flip: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_09
    (take && op == csfl_pkg::CSFL_OP_COMPLEMENT_CARRY) |=> flags[0] != $past(flags[0]))
    else $error("carry not complemented");
  a_bit_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_20
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_BIT) |=> flags[6] == !$past(b[req.bit_sel]))
    else $error("bit test zero wrong");
  a_blk_pv: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_14
    (clk_en && req_valid && op == csfl_pkg::CSFL_OP_BLKLD && req.counter == 16'h0000)
    |=> !flags[2])
    else $error("block pv not cleared");
  a_hold_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)  // RULE_23
    (!clk_en || (!req_valid && !reg_wr)) |=> flags == $past(flags))
    else $error("flags changed without cause");
  a_add_ovf: assert property (  // RULE_11
    (take && op == csfl_pkg::CSFL_OP_ADD && a[7] != b[7]) |=> !flags[csfl_pkg::FLAG_PV])
    else $error("unlike-sign add flagged overflow");
  a_sub_ovf: assert property (  // RULE_12
    (take && op == csfl_pkg::CSFL_OP_SUB && a[7] == b[7]) |=> !flags[csfl_pkg::FLAG_PV])
    else $error("like-sign subtract flagged overflow");
  a_add_half: assert property (  // RULE_17
    (take && op == csfl_pkg::CSFL_OP_ADD)
    |=> flags[csfl_pkg::FLAG_HALF] == $past({1'b0, a[3:0]} + b[3:0] > 5'h0f))
    else $error("add half carry wrong");
  a_or_parity: assert property (  // RULE_13
    (take && op == csfl_pkg::CSFL_OP_OR) |=> flags[csfl_pkg::FLAG_PV] == ~^$past(a | b))
    else $error("or parity wrong");
  a_vector_pv: assert property (  // RULE_15
    (take && op == csfl_pkg::CSFL_OP_LDAIR) |=> flags[csfl_pkg::FLAG_PV] == $past(req.ie_copy))
    else $error("vector load pv wrong");
  a_input_flags: assert property (  // RULE_16
    (take && op == csfl_pkg::CSFL_OP_INR)
    |=> {flags[csfl_pkg::FLAG_SIGN], flags[csfl_pkg::FLAG_ZERO]} == $past({b[7], b == 8'h00}))
    else $error("port input flags wrong");
  a_blkio_zero: assert property (  // RULE_21
    (take && op == csfl_pkg::CSFL_OP_BLKIO)
    |=> flags[csfl_pkg::FLAG_ZERO] == $past(req.b_dec == 8'h00))
    else $error("block io zero wrong");
  a_adjust_carry: assert property (  // RULE_05
    (take && op == csfl_pkg::CSFL_OP_DECIMAL_ADJUST_ACC && a > 8'h99)
    |=> flags[csfl_pkg::FLAG_CARRY])
    else $error("decimal adjust left carry clear");
  c_add_ovf: cover property (@(posedge clk_sys) clk_en && req_valid && is_add && ov_add);
  c_swap:    cover property (@(posedge clk_sys) clk_en && do_swap && !do_upd);
  c_adjust:  cover property (take && op == csfl_pkg::CSFL_OP_DECIMAL_ADJUST_ACC);
  c_sub_ovf: cover property (take && is_sub && ov_sub);
  c_count_end: cover property (take && op == csfl_pkg::CSFL_OP_BLKLD && req.counter == 16'h0000);
endmodule
`default_nettype wire

// File: design/csfl_pkg.sv
// package for the cpu status flag logic: flag layout, operation codes, register map
`default_nettype none
package csfl_pkg;
  // flag byte bit positions
  localparam int unsigned FLAG_SIGN   = 7;
  localparam int unsigned FLAG_ZERO   = 6;
  localparam int unsigned FLAG_UNU5   = 5;
  localparam int unsigned FLAG_HALF   = 4;
  localparam int unsigned FLAG_UNU3   = 3;
  localparam int unsigned FLAG_PV     = 2;
  localparam int unsigned FLAG_SUB    = 1;
  localparam int unsigned FLAG_CARRY  = 0;
  localparam int unsigned ACC_MSB     = 7;
  localparam int unsigned NIB_MSB     = 3;
  // flag reset value (left undefined by the cpu, we choose zero)
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  // register port map
  localparam logic [1:0]  ADDR_FLAGS     = 2'h0;
  localparam logic [1:0]  ADDR_FLAGS_ALT = 2'h1;
  localparam logic [1:0]  ADDR_CTRL      = 2'h2;
  localparam int unsigned CTRL_SWAP      = 0;
  // operation codes presented by the sequencer
  typedef enum logic [4:0] {
    CSFL_OP_NONE  = 5'h00,
    CSFL_OP_ADD   = 5'h01,
    CSFL_OP_ADC   = 5'h02,
    CSFL_OP_SUB   = 5'h03,
    CSFL_OP_SBC   = 5'h04,
    CSFL_OP_CMP   = 5'h05,
    CSFL_OP_AND   = 5'h06,
    CSFL_OP_OR    = 5'h07,
    CSFL_OP_XOR   = 5'h08,
    CSFL_OP_DECIMAL_ADJUST_ACC = 5'h09,
    CSFL_OP_RLC   = 5'h0a,
    CSFL_OP_RRC   = 5'h0b,
    CSFL_OP_RL    = 5'h0c,
    CSFL_OP_RR    = 5'h0d,
    CSFL_OP_SLA   = 5'h0e,
    CSFL_OP_SRA   = 5'h0f,
    CSFL_OP_SRL   = 5'h10,
    CSFL_OP_SET_CARRY = 5'h11,
    CSFL_OP_COMPLEMENT_CARRY = 5'h12,
    CSFL_OP_BIT   = 5'h13,
    CSFL_OP_BLKCP = 5'h14,
    CSFL_OP_BLKLD = 5'h15,
    CSFL_OP_LDAIR = 5'h16,
    CSFL_OP_INR   = 5'h17,
    CSFL_OP_BLKIO = 5'h18
  } csfl_op_t;
  // condition codes for jump, call and return tests
  typedef enum logic [2:0] {
    CSFL_CC_NZ = 3'h0, CSFL_CC_Z  = 3'h1, CSFL_CC_NC = 3'h2, CSFL_CC_C = 3'h3,
    CSFL_CC_PO = 3'h4, CSFL_CC_PE = 3'h5, CSFL_CC_P  = 3'h6, CSFL_CC_M = 3'h7
  } csfl_cc_t;
  // one flag-update request from the sequencer
  typedef struct packed {
    csfl_op_t    op;       // operation class
    logic [7:0]  opa;      // accumulator / operand a
    logic [7:0]  opb;      // operand b
    logic [2:0]  bit_sel;  // bit index for bit test
    logic [15:0] counter;  // byte counter pair, already decremented
    logic [7:0]  b_dec;    // b register, already decremented
    logic        ie_copy;  // interrupt_enable_copy state
  } csfl_req_t;
  // result handed back to the datapath
  typedef struct packed {
    logic [7:0] result;    // arithmetic / logical result byte
    logic [7:0] flags;     // updated flag byte
  } csfl_rsp_t;
endpackage
`default_nettype wire

// File: verif/cpu_status_flag_logic_bench.sv
// self-checking testbench for the condition flag logic
`timescale 1ns/1ns
`default_nettype none
module cpu_status_flag_logic_bench;
  // design ports
  logic                clk_sys;
  logic                arst_n;
  logic                clk_en;
  logic                req_valid;
  csfl_pkg::csfl_req_t req;
  csfl_pkg::csfl_rsp_t rsp;
  csfl_pkg::csfl_cc_t  cc_sel;
  logic                cc_true;
  logic [1:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  // bookkeeping
  int                  failures = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;

  csfl_flags csfl_flags_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .rsp(rsp),
    .cc_sel(cc_sel), .cc_true(cc_true),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle register write
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle under a mask
  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    cmp8("reg_rdata", exp & m, reg_rdata & m);
  endtask

  // reference: returns {checked bits, flags, result}; bits 3 and 5 always kept
  function automatic logic [23:0] model(input logic [4:0] code, input logic [7:0] a,
                                        input logic [7:0] b, input logic [7:0] pre);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] m;
    logic       ci;
    ci = pre[0] & (code == 5'h02 || code == 5'h04);
    f  = pre;
    m  = 8'h28;
    r  = a;
    case (code)
      // add, add with carry, sub, sub with borrow, compare
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
        if (code >= 5'h03) begin
          s    = {1'b0, a} - {1'b0, b} - {8'h00, ci};
          h    = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
          f[2] = (a[7] != b[7]) && (s[7] != a[7]);
        end else begin
          s    = {1'b0, a} + {1'b0, b} + {8'h00, ci};
          h    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
          f[2] = (a[7] == b[7]) && (s[7] != a[7]);
        end
        f[7] = s[7];
        f[6] = (s[7:0] == 8'h00);
        f[4] = h[4];
        f[1] = (code >= 5'h03);
        f[0] = s[8];
        m    = 8'hff;
        r    = (code == 5'h05) ? a : s[7:0];
      end
      5'h06, 5'h07, 5'h08: begin
        r    = (code == 5'h06) ? (a & b) : (code == 5'h07) ? (a | b) : (a ^ b);
        f[7] = r[7];
        f[6] = (r == 8'h00);
        f[2] = ~^r;
        f[0] = 1'b0;
        m    = 8'hed;
      end
      5'h09, 5'h11: begin f[0] = 1'b1; m = 8'h29; end
      5'h0a: begin r = {a[6:0], a[7]}; f[0] = a[7]; f[2] = ~^r; m = 8'h2d; end
      5'h0b: begin r = {a[0], a[7:1]}; f[0] = a[0]; f[2] = ~^r; m = 8'h2d; end
      5'h0c: begin r = {a[6:0], pre[0]}; f[0] = a[7]; f[2] = ~^r; m = 8'h2d; end
      5'h0d: begin r = {pre[0], a[7:1]}; f[0] = a[0]; f[2] = ~^r; m = 8'h2d; end
      5'h0e: begin r = {a[6:0], 1'b0}; f[0] = a[7]; m = 8'h29; end
      5'h0f: begin r = {a[7], a[7:1]}; f[0] = a[0]; m = 8'h29; end
      5'h10: begin r = {1'b0, a[7:1]}; f[0] = a[0]; m = 8'h29; end
      5'h12: begin f[0] = ~pre[0]; m = 8'h29; end
      5'h13: begin f[6] = ~b[b[2:0]]; m = 8'h68; end
      5'h14, 5'h15: begin f[2] = ({b, b} != 16'h0000); m = 8'h2c; end
      5'h16: begin r = b; f[2] = b[0]; m = 8'h2c; end
      5'h17: begin r = b; f[7] = b[7]; f[6] = (b == 8'h00); f[2] = ~^b; m = 8'hec; end
      5'h18: begin f[6] = (b == 8'h00); m = 8'h68; end
      default: ;
    endcase
    return {m, f, r};
  endfunction

  // preload flags, issue one op; b also feeds bit index, counters and enable copy
  task automatic do_op(input logic [4:0] code, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] pre);
    logic [23:0] e;
    e = model(code, a, b, pre);
    reg_write(csfl_pkg::ADDR_FLAGS, pre);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req       <= '{op: csfl_pkg::csfl_op_t'(code), opa: a, opb: b, bit_sel: b[2:0],
                   counter: {b, b}, b_dec: b, ie_copy: b[0]};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    cmp8("rsp flags", e[15:8] & e[23:16], rsp.flags & e[23:16]);
    if (code inside {[5'h01:5'h08], [5'h0a:5'h10], [5'h16:5'h17]}) begin
      cmp8("rsp result", e[7:0], rsp.result);
    end
    reg_read(csfl_pkg::ADDR_FLAGS, e[15:8], e[23:16]);
  endtask

  // walk all eight condition codes against one flag byte
  task automatic cc_scan(input logic [7:0] fl);
    logic [7:0] t;
    t = {fl[7], ~fl[7], fl[2], ~fl[2], fl[0], ~fl[0], fl[6], ~fl[6]};
    reg_write(csfl_pkg::ADDR_FLAGS, fl);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      cc_sel <= csfl_pkg::csfl_cc_t'(i[2:0]);
      @(negedge clk_sys);
      cmp8("cc_true", {7'h00, t[i]}, {7'h00, cc_true});
    end
  endtask

  // register copies: reset value, unmapped read, alternate and swap
  task automatic reg_scenario();
    reg_read(csfl_pkg::ADDR_FLAGS, 8'h00, 8'hff);
    reg_read(csfl_pkg::ADDR_FLAGS_ALT, 8'h00, 8'hff);
    reg_read(2'h3, 8'h00, 8'hff);
    reg_write(csfl_pkg::ADDR_FLAGS, 8'h3c);
    reg_write(csfl_pkg::ADDR_FLAGS_ALT, 8'ha5);
    reg_write(csfl_pkg::ADDR_CTRL, 8'h01);
    reg_read(csfl_pkg::ADDR_FLAGS, 8'ha5, 8'hff);
    reg_read(csfl_pkg::ADDR_FLAGS_ALT, 8'h3c, 8'hff);
  endtask

  // a register write beside an op loses; a frozen clock enable drops the op
  task automatic clash_scenario();
    reg_write(csfl_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req       <= '{op: csfl_pkg::CSFL_OP_ADD, opa: 8'h01, opb: 8'h01, default: '0};
    reg_wr    <= 1'b1;
    reg_addr  <= csfl_pkg::ADDR_FLAGS;
    reg_wdata <= 8'hff;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    reg_wr    <= 1'b0;
    reg_read(csfl_pkg::ADDR_FLAGS, 8'h00, 8'hff);
    @(posedge clk_sys);
    clk_en    <= 1'b0;
    req_valid <= 1'b1;
    req       <= '{op: csfl_pkg::CSFL_OP_SET_CARRY, default: '0};
    @(posedge clk_sys);
    clk_en    <= 1'b1;
    req_valid <= 1'b0;
    reg_read(csfl_pkg::ADDR_FLAGS, 8'h00, 8'h01);
  endtask

  initial begin
    arst_n = 1'b0; clk_en = 1'b1; req_valid = 1'b0; req = '0;
    cc_sel = csfl_pkg::CSFL_CC_NZ; reg_addr = 2'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    reg_scenario();
    // arithmetic: codes 01 add, 02 adc, 03 sub, 04 sbc, 05 compare
    do_op(5'h01, 8'h78, 8'h69, 8'h28);
    do_op(5'h01, 8'hff, 8'h01, 8'h00);
    do_op(5'h01, 8'h50, 8'hc0, 8'h28);
    do_op(5'h02, 8'h0f, 8'h00, 8'h29);
    do_op(5'h03, 8'h7f, 8'hc0, 8'h28);
    do_op(5'h03, 8'h10, 8'h01, 8'h00);
    do_op(5'h04, 8'h00, 8'h00, 8'h29);
    do_op(5'h03, 8'h40, 8'h50, 8'h28);
    do_op(5'h05, 8'h5a, 8'h5a, 8'h28);
    do_op(5'h05, 8'h5a, 8'h5b, 8'h00);
    // logic ops and decimal adjust
    do_op(5'h06, 8'hf0, 8'h0f, 8'h29);
    do_op(5'h07, 8'h01, 8'h02, 8'h29);
    do_op(5'h08, 8'hff, 8'h01, 8'h29);
    do_op(5'h09, 8'ha0, 8'h00, 8'h28);
    // rotates and shifts, codes 0a to 10
    do_op(5'h0a, 8'h81, 8'h00, 8'h28);
    do_op(5'h0a, 8'h40, 8'h00, 8'h29);
    do_op(5'h0b, 8'h81, 8'h00, 8'h28);
    do_op(5'h0c, 8'h80, 8'h00, 8'h28);
    do_op(5'h0d, 8'h01, 8'h00, 8'h29);
    do_op(5'h0e, 8'h80, 8'h00, 8'h28);
    do_op(5'h0f, 8'h81, 8'h00, 8'h28);
    do_op(5'h10, 8'h02, 8'h00, 8'h29);
    // carry set and complement
    do_op(5'h11, 8'h00, 8'h00, 8'h28);
    do_op(5'h12, 8'h00, 8'h00, 8'h29);
    do_op(5'h12, 8'h00, 8'h00, 8'h28);
    // bit test, block ops, vector load, port input, block io
    do_op(5'h13, 8'hff, 8'h05, 8'h28);
    do_op(5'h13, 8'h3b, 8'h3b, 8'h68);
    do_op(5'h14, 8'h00, 8'h00, 8'h2c);
    do_op(5'h14, 8'h00, 8'h01, 8'h28);
    do_op(5'h15, 8'h00, 8'h00, 8'h2c);
    do_op(5'h15, 8'h00, 8'h80, 8'h00);
    do_op(5'h16, 8'h00, 8'h01, 8'h28);
    do_op(5'h16, 8'h00, 8'h00, 8'h2c);
    do_op(5'h17, 8'h00, 8'h80, 8'h68);
    do_op(5'h17, 8'h00, 8'h00, 8'h28);
    do_op(5'h18, 8'h00, 8'h00, 8'h28);
    do_op(5'h18, 8'h00, 8'h01, 8'h68);
    clash_scenario();
    cc_scan(8'hc5);
    cc_scan(8'h12);
    tally_and_finish();
  end
endmodule
`default_nettype wire
